// File: logic/sp_ctl.sv
// Behaviour
// - Mode 00 shifts 8 bits at clk/4 or /12
// - Mode 10 sends 11-bit frames at clk/32 or /64
// - Mode 01 10-bit, mode 11 11-bit variable
// - Bit 7 is mode-high or sticky framing error
// - Filter bit ignored in synchronous mode
// - 10-bit filtered frame needs stop bit one
// - 11-bit filtered frame needs ninth bit one
// - Receive starts only while receive enable set
// - Ninth sent bit comes from tx_ninth_bit
// - rx_ninth_bit holds ninth or stop bit
// - Transmit done at 8th bit or stop start
// - Receive done at 8th bit or mid stop
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sp_ctl
  import sp_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_ovf,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe,
  output logic txd,
  output logic irq,
  output logic serial_event
);
  // Control register fields
  logic mode_hi;
  logic mode_lo;
  logic filt;
  logic ren;
  logic tb9;
  logic rb9;
  logic tx_done;
  logic rx_done;
  logic fe_flag;
  logic [2:0] cfg;
  logic [2:0] mask;
  logic [2:0] status;
  logic [7:0] rx_buf;
  sp_mode_e mode;
  // Bus decode
  logic bus_go;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_data;
  logic [7:0] rd_val;
  // Rate and pin
  logic tick;
  logic div_en;
  logic [5:0] div_lim;
  logic rxd_s;
  logic rxd_q;
  // Shifter
  sp_sh_e sh_state;
  logic [10:0] sh_reg;
  logic [3:0] sh_cnt;
  logic [3:0] sh_ph;
  logic sh_rx;
  logic [3:0] stop_idx;
  logic sync_go;
  logic sync_done;
  logic tx_set;
  // Receiver
  sp_rx_e rx_state;
  logic [3:0] rx_ph;
  logic [3:0] rx_cnt;
  logic [9:0] rx_sh;
  logic [9:0] rx_new;
  logic rx_fin;
  logic accept;
  logic rx_set;
  logic fe_set;
  sp_frame_s frm;
  logic [2:0] ev;

  assign mode = sp_mode_e'({mode_hi, mode_lo});
  assign stop_idx = mode_hi ? SP_STOP_IDX_11 : SP_STOP_IDX_10;

  // Wishbone decode; request taken on the cycle before ack
  assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = bus_go & wb_we_i & wb_sel_i[0];
  assign rd = bus_go & ~wb_we_i;
  assign wr_ctrl = wr && (wb_adr_i == SP_OFF_CTRL);
  assign wr_data = wr && (wb_adr_i == SP_OFF_DATA);

  // Read mux; unmapped reads zero
  always_comb begin
    rd_val = 8'h00;
    unique case (wb_adr_i)
      SP_OFF_CTRL: rd_val = {cfg[SP_CFG_FE_SEL] ? fe_flag : mode_hi, mode_lo, filt, ren,
                             tb9, rb9, tx_done, rx_done};
      SP_OFF_DATA: rd_val = rx_buf;
      SP_OFF_STAT: rd_val = {5'h00, status};
      SP_OFF_MASK: rd_val = {5'h00, mask};
      SP_OFF_CFG: rd_val = {5'h00, cfg};
      default: rd_val = 8'h00;
    endcase
  end

  // Ack one cycle after the request, read data with it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_go;
      wb_dat_o <= rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // Receive pin synchroniser and edge history
  sp_ctl_sync #(.RST_VAL(1'b1)) u_rxd_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(rxd_i),
    .q(rxd_s)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_s;
    end
  end

  // Rate select: half-bit ticks in mode 0, 16x ticks otherwise
  always_comb begin
    div_en = 1'b1;
    unique case (mode)
      SP_M_SYNC: div_lim = cfg[SP_CFG_M0_FAST] ? SP_M0_LIM_FAST : SP_M0_LIM_SLOW;
      SP_M_FIX11: div_lim = cfg[SP_CFG_DOUBLE] ? SP_M2_LIM_FAST : SP_M2_LIM_SLOW;
      default: begin
        div_en = timer_ovf;
        div_lim = cfg[SP_CFG_DOUBLE] ? SP_VR_LIM_FAST : SP_VR_LIM_SLOW;
      end
    endcase
  end

  sp_ctl_div #(.W(6)) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .en(div_en),
    .limit(div_lim),
    .tick(tick)
  );

  // Shifter events
  assign sync_go = (mode == SP_M_SYNC) && ren && !rx_done && !wr_data;
  assign sync_done = (sh_state == SP_SH_SYNC) && tick && sh_ph[0] && (sh_cnt == SP_SYNC_LAST);
  assign tx_set = ((sh_state == SP_SH_ASYNC) && tick && (sh_ph == SP_PH_LAST) &&
                   (sh_cnt == stop_idx - 4'h1)) || (sync_done && !sh_rx);

  // Transmit shifter, also runs the synchronous exchange
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_state <= SP_SH_IDLE;
      sh_reg <= 11'h7ff;
      sh_cnt <= 4'h0;
      sh_ph <= 4'h0;
      sh_rx <= 1'b0;
      txd <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      unique case (sh_state)
        SP_SH_IDLE: begin
          sh_cnt <= 4'h0;
          sh_ph <= 4'h0;
          txd <= 1'b1;
          if (wr_data && (mode == SP_M_SYNC)) begin
            // Drive first data bit at once
            sh_reg <= {3'h7, wb_dat_i[7:0]};
            sh_rx <= 1'b0;
            rxd_o <= wb_dat_i[0];
            rxd_oe <= 1'b1;
            sh_state <= SP_SH_SYNC;
          end else if (wr_data) begin
            // Start, data, ninth or stop, stop
            sh_reg <= {1'b1, mode_hi ? tb9 : 1'b1, wb_dat_i[7:0], 1'b0};
            sh_rx <= 1'b0;
            txd <= 1'b0;
            sh_state <= SP_SH_ASYNC;
          end else if (sync_go) begin
            sh_rx <= 1'b1;
            rxd_oe <= 1'b0;
            sh_state <= SP_SH_SYNC;
          end
        end
        SP_SH_ASYNC: begin
          if (tick) begin
            sh_ph <= sh_ph + 4'h1;
            if (sh_ph == SP_PH_LAST) begin
              if (sh_cnt == stop_idx) begin
                sh_state <= SP_SH_IDLE;
              end else begin
                // Next bit, line follows the shifter
                sh_cnt <= sh_cnt + 4'h1;
                sh_reg <= {1'b1, sh_reg[10:1]};
                txd <= sh_reg[1];
              end
            end
          end
        end
        SP_SH_SYNC: begin
          if (tick && !sh_ph[0]) begin
            // Clock low half, data set up
            sh_ph <= 4'h1;
            txd <= 1'b0;
            if (!sh_rx) begin
              rxd_o <= sh_reg[0];
            end
          end else if (tick) begin
            // Clock rises, sample or advance
            sh_ph <= 4'h0;
            txd <= 1'b1;
            sh_reg <= {sh_reg[10:8], sh_rx ? rxd_s : 1'b1, sh_reg[7:1]};
            sh_cnt <= sh_cnt + 4'h1;
            if (sh_cnt == SP_SYNC_LAST) begin
              rxd_oe <= 1'b0;
              rxd_o <= 1'b1;
              sh_state <= SP_SH_IDLE;
            end
          end
        end
        default: sh_state <= SP_SH_IDLE;
      endcase
    end
  end

  // Asynchronous frame fields as the last bit arrives
  assign rx_new = {rxd_s, rx_sh[9:1]};
  always_comb begin
    if (mode_hi) begin
      frm = '{data: rx_new[7:0], ninth: rx_new[8], stop: rx_new[9]};
    end else begin
      frm = '{data: rx_new[8:1], ninth: rx_new[9], stop: rx_new[9]};
    end
  end

  // Finish at the middle of the stop bit
  assign rx_fin = (rx_state == SP_RX_BITS) && tick && (rx_ph == SP_PH_LAST) &&
                  (rx_cnt == stop_idx - 4'h1);
  // Multiprocessor filter
  assign accept = !filt || (mode_hi ? frm.ninth : frm.stop);
  // Synchronous receive ignores the filter
  assign rx_set = (rx_fin && accept) || (sync_done && sh_rx);
  assign fe_set = rx_fin && !frm.stop;

  // Asynchronous receiver, 16x oversampled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= SP_RX_IDLE;
      rx_ph <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 10'h3ff;
    end else begin
      unique case (rx_state)
        SP_RX_IDLE: begin
          rx_ph <= 4'h0;
          rx_cnt <= 4'h0;
          if ((mode != SP_M_SYNC) && ren && rxd_q && !rxd_s) begin
            rx_state <= SP_RX_START;
          end
        end
        SP_RX_START: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == SP_PH_MID) begin
              // False start if line is high again
              rx_state <= rxd_s ? SP_RX_IDLE : SP_RX_BITS;
              rx_ph <= 4'h0;
            end
          end
        end
        SP_RX_BITS: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == SP_PH_LAST) begin
              rx_sh <= rx_new;
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_fin) begin
                rx_state <= SP_RX_IDLE;
              end
            end
          end
        end
        default: rx_state <= SP_RX_IDLE;
      endcase
    end
  end

  // Receive buffer and received ninth bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf <= 8'h00;
      rb9 <= SP_CTRL_RST[SP_CTL_RB9];
    end else if (rx_set && (mode == SP_M_SYNC)) begin
      rx_buf <= {rxd_s, sh_reg[7:1]};
    end else if (rx_set) begin
      rx_buf <= frm.data;
      rb9 <= mode_hi ? frm.ninth : frm.stop;
    end else if (wr_ctrl) begin
      rb9 <= wb_dat_i[SP_CTL_RB9];
    end
  end

  // Software fields of the serial control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_hi <= SP_CTRL_RST[SP_CTL_MODE_HI];
      mode_lo <= SP_CTRL_RST[SP_CTL_MODE_LO];
      filt <= SP_CTRL_RST[SP_CTL_FILT];
      ren <= SP_CTRL_RST[SP_CTL_REN];
      tb9 <= SP_CTRL_RST[SP_CTL_TB9];
      cfg <= SP_CFG_RST;
      mask <= SP_MASK_RST;
    end else if (wr) begin
      if (wb_adr_i == SP_OFF_CTRL) begin
        // Bit 7 goes to the mode only when not the error flag
        if (!cfg[SP_CFG_FE_SEL]) begin
          mode_hi <= wb_dat_i[SP_CTL_MODE_HI];
        end
        mode_lo <= wb_dat_i[SP_CTL_MODE_LO];
        filt <= wb_dat_i[SP_CTL_FILT];
        ren <= wb_dat_i[SP_CTL_REN];
        tb9 <= wb_dat_i[SP_CTL_TB9];
      end
      if (wb_adr_i == SP_OFF_CFG) begin
        cfg <= wb_dat_i[2:0];
      end
      if (wb_adr_i == SP_OFF_MASK) begin
        mask <= wb_dat_i[2:0];
      end
    end
  end

  // Done and error flags: hardware set wins over software write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_done <= SP_CTRL_RST[SP_CTL_TXD];
      rx_done <= SP_CTRL_RST[SP_CTL_RXD];
      fe_flag <= 1'b0;
    end else begin
      tx_done <= tx_set | (wr_ctrl ? wb_dat_i[SP_CTL_TXD] : tx_done);
      rx_done <= rx_set | (wr_ctrl ? wb_dat_i[SP_CTL_RXD] : rx_done);
      fe_flag <= fe_set | ((wr_ctrl && cfg[SP_CFG_FE_SEL]) ?
                           wb_dat_i[SP_CTL_MODE_HI] : fe_flag);
    end
  end

  // Sticky interrupt status, cleared by reading it
  always_comb begin
    ev = 3'h0;
    ev[SP_EV_TX] = tx_set;
    ev[SP_EV_RX] = rx_set;
    ev[SP_EV_FE] = fe_set;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= SP_STAT_RST;
      irq <= 1'b0;
      serial_event <= 1'b0;
    end else begin
      status <= ev | ((rd && (wb_adr_i == SP_OFF_STAT)) ? 3'h0 : status);
      irq <= |(status & mask);
      serial_event <= tx_done | rx_done;
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_gap5;
    (!tick)[*5] ##1 tick;
  endsequence
  sequence s_gap3;
    (!tick)[*3] ##1 tick;
  endsequence

  // Spacing only holds while no register write can move the divider limit
  AST_M0_SLOW: assert property (disable iff (!rst_b || wr)
    (tick && mode == SP_M_SYNC && !cfg[SP_CFG_M0_FAST]) |-> ##1 s_gap5)
    else $error("mode 0 half bit not 6 clocks");
  AST_M2_SLOW: assert property (disable iff (!rst_b || wr)
    (tick && mode == SP_M_FIX11 && !cfg[SP_CFG_DOUBLE]) |-> ##1 s_gap3)
    else $error("mode 2 tick not 4 clocks");
  // Tick registered one cycle late, so the previous cycle's mode must agree
  AST_VAR_TICK: assert property ((tick && mode_lo && $past(mode_lo)) |-> $past(timer_ovf))
    else $error("variable rate tick without timer overflow");
  AST_START_LOW: assert property ((wr_data && sh_state == SP_SH_IDLE && mode != SP_M_SYNC)
    |=> !txd [*2]) else $error("start bit not low");
  AST_TX_STOP: assert property ((tx_set && mode != SP_M_SYNC) |=> (txd && tx_done))
    else $error("transmit done not at stop bit");
  AST_FILT10: assert property ((rx_set && mode == SP_M_ASYNC10 && filt) |-> frm.stop)
    else $error("filtered 10-bit frame with low stop");
  AST_FILT11: assert property ((rx_set && mode_hi && filt) |-> frm.ninth)
    else $error("filtered 11-bit frame with low ninth bit");
  AST_REN: assert property ((rx_state == SP_RX_START && $past(rx_state) == SP_RX_IDLE)
    |-> $past(ren)) else $error("reception started while disabled");
  AST_RB9: assert property ((rx_set && mode_hi) |=> rb9 == $past(frm.ninth))
    else $error("ninth bit not captured");
  AST_FE: assert property (fe_set |=> fe_flag ##1 (fe_flag || $past(wr_ctrl)))
    else $error("framing error not held");
  AST_M0_RX: assert property ((sync_done && sh_rx) |=> rx_done && rx_buf == $past({rxd_s, sh_reg[7:1]}))
    else $error("synchronous receive not completed");
  AST_EVENT: assert property ((tx_done || rx_done) |=> serial_event)
    else $error("serial event request not raised");
endmodule
`default_nettype wire

// File: logic/sp_ctl_div.sv
`timescale 1ns/100ps
`default_nettype none
module sp_ctl_div #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic tick
);
  // Enable counter
  logic [W-1:0] cnt;

  // One-cycle tick every limit+1 enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (en && (cnt >= limit)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else if (en) begin
      cnt <= cnt + W'(1);
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: logic/sp_ctl_pkg.sv
`default_nettype none
package sp_ctl_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] SP_OFF_CTRL = 8'h98;
  localparam logic [7:0] SP_OFF_DATA = 8'h9c;
  localparam logic [7:0] SP_OFF_STAT = 8'ha0;
  localparam logic [7:0] SP_OFF_MASK = 8'ha4;
  localparam logic [7:0] SP_OFF_CFG = 8'ha8;
  // Serial control bit positions
  localparam int SP_CTL_MODE_HI = 7;
  localparam int SP_CTL_MODE_LO = 6;
  localparam int SP_CTL_FILT = 5;
  localparam int SP_CTL_REN = 4;
  localparam int SP_CTL_TB9 = 3;
  localparam int SP_CTL_RB9 = 2;
  localparam int SP_CTL_TXD = 1;
  localparam int SP_CTL_RXD = 0;
  // Configuration bit positions
  localparam int SP_CFG_FE_SEL = 0;
  localparam int SP_CFG_DOUBLE = 1;
  localparam int SP_CFG_M0_FAST = 2;
  // Event bit positions in status and mask
  localparam int SP_EV_TX = 0;
  localparam int SP_EV_RX = 1;
  localparam int SP_EV_FE = 2;
  // Reset values
  localparam logic [7:0] SP_CTRL_RST = 8'h00;
  localparam logic [2:0] SP_CFG_RST = 3'h0;
  localparam logic [2:0] SP_MASK_RST = 3'h0;
  localparam logic [2:0] SP_STAT_RST = 3'h0;
  // Divider limits: tick every limit+1 enables
  localparam logic [5:0] SP_M0_LIM_SLOW = 6'h05;
  localparam logic [5:0] SP_M0_LIM_FAST = 6'h01;
  localparam logic [5:0] SP_M2_LIM_SLOW = 6'h03;
  localparam logic [5:0] SP_M2_LIM_FAST = 6'h01;
  localparam logic [5:0] SP_VR_LIM_SLOW = 6'h01;
  localparam logic [5:0] SP_VR_LIM_FAST = 6'h00;
  // Oversampling phases and bit indices
  localparam logic [3:0] SP_PH_MID = 4'h7;
  localparam logic [3:0] SP_PH_LAST = 4'hf;
  localparam logic [3:0] SP_STOP_IDX_10 = 4'h9;
  localparam logic [3:0] SP_STOP_IDX_11 = 4'ha;
  localparam logic [3:0] SP_SYNC_LAST = 4'h7;
  // Operating modes, high select bit first
  typedef enum logic [1:0] {
    SP_M_SYNC = 2'b00,
    SP_M_ASYNC10 = 2'b01,
    SP_M_FIX11 = 2'b10,
    SP_M_VAR11 = 2'b11
  } sp_mode_e;
  // Shifter states
  typedef enum logic [1:0] {
    SP_SH_IDLE = 2'b00,
    SP_SH_ASYNC = 2'b01,
    SP_SH_SYNC = 2'b10
  } sp_sh_e;
  // Receiver states
  typedef enum logic [1:0] {
    SP_RX_IDLE = 2'b00,
    SP_RX_START = 2'b01,
    SP_RX_BITS = 2'b10
  } sp_rx_e;
  // One received asynchronous frame
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop;
  } sp_frame_s;
endpackage
`default_nettype wire

// File: logic/sp_ctl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sp_ctl_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  // Three-stage chain; first stage feeds only the second
  logic s1;
  logic s2;
  logic s3;

  // Shift pin into the clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once the last two stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RST_VAL;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule
`default_nettype wire

// File: test/sp_ctl_remote.sv
`timescale 1ns/100ps
`default_nettype none
// Remote serial node: drives the receive line, watches the send line
module sp_ctl_remote (
  input wire logic clk,
  input wire logic txd,
  input wire logic dq,
  output logic rxd
);
  // Line idles high between frames
  initial rxd = 1'b1;
  // One frame out, low start then LSB first
  task automatic send(input logic [7:0] d, input logic nin, input logic stp,
                      input logic eleven, input int bitc);
    logic [10:0] fr;
    int n;
    fr = eleven ? {stp, nin, d, 1'b0} : {1'b1, stp, d, 1'b0};
    n = eleven ? 11 : 10;
    for (int k = 0; k < n; k++) begin
      rxd <= fr[k];
      repeat (bitc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // One 11-bit frame in, sampled mid-bit; returns stop, ninth, data
  task automatic capture(input int bitc, output logic [9:0] got);
    logic [10:0] sh;
    int n;
    n = 0;
    sh = 11'h000;
    while (txd !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (bitc / 2) @(posedge clk);
    for (int k = 0; k < 11; k++) begin
      sh = {txd, sh[10:1]};
      if (k < 10) repeat (bitc) @(posedge clk);
    end
    got = sh[10:1];
  endtask
  // Synchronous byte: drive after the shift clock falls, take the line before it rises
  task automatic sync_xfer(input logic [7:0] dout, output logic [7:0] din);
    logic lo;
    int n;
    n = 0;
    lo = 1'b1;
    din = 8'h00;
    for (int k = 0; k < 8; k++) begin
      while (txd !== 1'b0 && n < 5000) begin
        @(posedge clk);
        n++;
      end
      rxd <= dout[k];
      while (txd !== 1'b1 && n < 5000) begin
        lo = dq;
        @(posedge clk);
        n++;
      end
      din = {lo, din[7:1]};
    end
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: test/test_serial_port_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_control;
  import sp_ctl_pkg::*;
  logic clk, rst_b, cyc, stb, we, timer_ovf, rxd_line, rmt_rxd;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic ack, rxd_o, rxd_oe, txd, irq, sev;
  int miscompares, checks_done, cycles;
  // Pin level seen by the receiver
  assign rxd_line = rxd_oe ? rxd_o : rmt_rxd;
  sp_ctl u_sp_ctl (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_ovf(timer_ovf), .rxd_i(rxd_line), .rxd_o(rxd_o),
    .rxd_oe(rxd_oe), .txd(txd), .irq(irq), .serial_event(sev));
  sp_ctl_remote u_sp_ctl_remote (.clk(clk), .txd(txd), .dq(rxd_line), .rxd(rmt_rxd));
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Timer overflow every second cycle
  always @(posedge clk) timer_ovf <= rst_b ? ~timer_ovf : 1'b0;
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic Wishbone single cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) miscompares++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  logic [7:0] q, d, exp_data;
  logic [9:0] got;
  logic [1:0] m;
  logic [7:0] offs [6];
  logic nin, stp, filt, ren, acc;
  initial begin
    {cyc, stb, we, timer_ovf, rst_b} = 5'h00;
    adr = 8'h00;
    wdat = 32'h00000000;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    exp_data = 8'h00;
    void'($urandom(78643));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place reads zero
    offs = '{SP_OFF_CTRL, SP_OFF_DATA, SP_OFF_STAT, SP_OFF_MASK, SP_OFF_CFG, 8'hb0};
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, offs[k], 8'h00, q);
      chk("reset", {24'h0, q}, 32'h0);
    end
    // Transmit, normal and doubled rate
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, SP_OFF_CFG, 8'(j * 2), q);
      nin = 1'($urandom);
      d = 8'($urandom);
      bus(1'b1, SP_OFF_CTRL, {1'b1, 1'(j), 2'b00, nin, 3'b000}, q);
      fork
        u_sp_ctl_remote.capture(j ? 32 : 64, got);
        bus(1'b1, SP_OFF_DATA, d, q);
      join
      chk("tx frame", {22'h0, got}, {22'h0, 1'b1, nin, d});
      bus(1'b0, SP_OFF_CTRL, 8'h00, q);
      chk("tx done", {31'h0, q[SP_CTL_TXD]}, 32'h1);
      chk("event tx", {31'h0, sev}, 32'h1);
      repeat (j ? 200 : 400) @(posedge clk);
      bus(1'b1, SP_OFF_CTRL, 8'h00, q);
      bus(1'b0, SP_OFF_STAT, 8'h00, q);
    end
    // Synchronous mode: send at both rates, then receive with the filter set
    for (int j = 0; j < 3; j++) begin
      bus(1'b1, SP_OFF_CFG, (j == 1) ? 8'h04 : 8'h00, q);
      d = 8'($urandom);
      fork
        u_sp_ctl_remote.sync_xfer(d, got[7:0]);
        if (j == 2) bus(1'b1, SP_OFF_CTRL, 8'h30, q);
        else bus(1'b1, SP_OFF_DATA, d, q);
      join
      repeat (4) @(posedge clk);
      bus(1'b0, SP_OFF_CTRL, 8'h00, q);
      if (j < 2) begin
        chk("sync tx", {24'h0, got[7:0]}, {24'h0, d});
        chk("sync tx done", {31'h0, q[SP_CTL_TXD]}, 32'h1);
      end else begin
        exp_data = d;
        chk("sync rx done", {31'h0, q[SP_CTL_RXD]}, 32'h1);
        bus(1'b0, SP_OFF_DATA, 8'h00, q);
        chk("sync rx data", {24'h0, q}, {24'h0, exp_data});
      end
      bus(1'b1, SP_OFF_CTRL, 8'h00, q);
      bus(1'b0, SP_OFF_STAT, 8'h00, q);
    end
    bus(1'b1, SP_OFF_CFG, 8'h00, q);
    bus(1'b1, SP_OFF_MASK, 8'h02, q);
    // Receive over modes, filter and enable
    for (int i = 0; i < 12; i++) begin
      m = 2'(1 + i % 3);
      filt = 1'($urandom);
      ren = (i != 11);
      d = 8'($urandom);
      nin = 1'($urandom);
      stp = (m == 2'b01) ? 1'($urandom) : 1'b1;
      bus(1'b1, SP_OFF_CTRL, {m, filt, ren, 4'h0}, q);
      u_sp_ctl_remote.send(d, nin, stp, m != 2'b01, 64);
      repeat (20) @(posedge clk);
      acc = ren && (!filt || (m == 2'b01 ? stp : nin));
      if (acc) exp_data = d;
      chk("irq", {31'h0, irq}, {31'h0, acc});
      chk("event rx", {31'h0, sev}, {31'h0, acc});
      bus(1'b0, SP_OFF_CTRL, 8'h00, q);
      chk("rx done", {31'h0, q[SP_CTL_RXD]}, {31'h0, acc});
      if (acc) chk("rx ninth", {31'h0, q[SP_CTL_RB9]}, {31'h0, m == 2'b01 ? stp : nin});
      bus(1'b0, SP_OFF_DATA, 8'h00, q);
      chk("rx data", {24'h0, q}, {24'h0, exp_data});
      bus(1'b0, SP_OFF_STAT, 8'h00, q);
      chk("stat rx", {31'h0, q[SP_EV_RX]}, {31'h0, acc});
      repeat (3) @(posedge clk);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
    // Framing error flag in bit 7; pick 10-bit mode before bit 7 turns into the flag
    bus(1'b1, SP_OFF_CTRL, 8'h50, q);
    bus(1'b1, SP_OFF_CFG, 8'h01, q);
    u_sp_ctl_remote.send(8'h5a, 1'b0, 1'b0, 1'b0, 64);
    repeat (20) @(posedge clk);
    bus(1'b0, SP_OFF_CTRL, 8'h00, q);
    chk("frame err", {31'h0, q[SP_CTL_MODE_HI]}, 32'h1);
    bus(1'b0, SP_OFF_STAT, 8'h00, q);
    chk("stat fe", {31'h0, q[SP_EV_FE]}, 32'h1);
    bus(1'b1, SP_OFF_CTRL, 8'h50, q);
    bus(1'b0, SP_OFF_CTRL, 8'h00, q);
    chk("fe clear", {31'h0, q[SP_CTL_MODE_HI]}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
